// >>> dv/pecu_core_model.sv
// pecu_core_model: core side issuing branch, miss and fill pulses
// assumes: bench calls the send tasks between clock edges
`timescale 1ns/1ns
`default_nettype none
module pecu_core_model (
    // clock
    input  wire logic                  sys_clk,
    // event pulses toward the unit
    output var pecu_pkg::pecu_branch_t br,
    output var pecu_pkg::pecu_miss_t   miss,
    output var pecu_pkg::pecu_fill_t   fill
);
    pecu_pkg::pecu_branch_t br_n;
    pecu_pkg::pecu_miss_t   miss_n;
    pecu_pkg::pecu_fill_t   fill_n;
    logic                   br_go = 1'b0;
    logic                   miss_go = 1'b0;
    logic                   fill_go = 1'b0;
    // idle payload inverts so a stale address never passes as fresh
    always @(posedge sys_clk) begin
        br <= br_go ? br_n : {1'b0, br.cls, 3'b000, ~br.vaddr};
        miss <= miss_go ? miss_n : {5'b00000, ~miss.vaddr, ~miss.paddr};
        fill <= fill_go ? fill_n : '0;
    end
    task automatic hold_one(ref logic go);
        // raise off the edge so the pulse starts at a known edge, one cycle long
        #1 go = 1'b1;
        @(posedge sys_clk);
        #1 go = 1'b0;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic send_br(input pecu_pkg::pecu_branch_t b);
        br_n = b;
        hold_one(br_go);
    endtask
    task automatic send_miss(input pecu_pkg::pecu_miss_t m);
        miss_n = m;
        hold_one(miss_go);
    endtask
    task automatic send_fill(input pecu_pkg::pecu_fill_t f);
        fill_n = f;
        hold_one(fill_go);
    endtask
endmodule
`default_nettype wire

// >>> dv/pecu_top_asserts.sv
// pecu_top_asserts: port-level checks of the event capture unit
// assumes: bound into pecu_top; sees its ports only, one clock domain
`timescale 1ns/1ns
`default_nettype none
module pecu_top_asserts (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   reset_n,
    // watched ports
    input  wire logic                   reg_rd,
    input  wire logic [31:0]            reg_rdata,
    input  wire pecu_pkg::pecu_mode_t   mode,
    input  wire pecu_pkg::pecu_branch_t br,
    input  wire logic [2:0]             br_exec_count,
    input  wire pecu_pkg::pecu_miss_t   miss,
    input  wire pecu_pkg::pecu_fill_t   fill,
    input  wire logic                   branch_captured,
    input  wire logic                   cache_captured,
    input  wire logic [2:0]             br_exec_event,
    input  wire logic                   miss_pending
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // fill taken while pending, with no fresh capture racing it
    sequence s_fill_done;
        miss_pending && fill.valid ##1 !cache_captured;
    endsequence
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data outside its slot");
    a_exec_clamp: assert property (1'b1 |=> br_exec_event ==
        (($past(br_exec_count) > 3'h4) ? 3'h4 : $past(br_exec_count)))
        else $error("branch count not clamped");
    a_pend_rise: assert property (cache_captured && !fill.valid |=> miss_pending)
        else $error("pending not raised");
    a_pend_clear: assert property (s_fill_done |-> !miss_pending)
        else $error("pending not cleared");
    a_pend_hold: assert property (miss_pending && !fill.valid |=> miss_pending)
        else $error("pending dropped early");
    a_br_cause: assert property (branch_captured |-> $past(br.valid))
        else $error("branch capture without branch");
    a_miss_cause: assert property (cache_captured |->
        $past(miss.ifetch || miss.load || miss.store))
        else $error("cache capture without miss");
    a_mode_gate: assert property ((br.valid || miss.load) && mode == 4'h0
        |=> !branch_captured && !cache_captured)
        else $error("capture with no context enabled");
endmodule
bind pecu_top pecu_top_asserts pecu_top_asserts_i (.sys_clk, .reset_n, .reg_rd,
    .reg_rdata, .mode, .br, .br_exec_count, .miss, .fill, .branch_captured,
    .cache_captured, .br_exec_event, .miss_pending);
`default_nettype wire

// >>> dv/tb_top.sv
// tb_top: register and event tests of the capture unit
// assumes: core model drives events; bench drives registers and counts
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic                   sys_clk = 1'b0;
    logic                   reset_n = 1'b0;
    logic [2:0]             reg_addr = 3'h0;
    logic [31:0]            reg_wdata = 32'h0000_0000;
    logic                   reg_wr = 1'b0;
    logic                   reg_rd = 1'b0;
    logic [31:0]            reg_rdata;
    pecu_pkg::pecu_mode_t   mode = 4'h0;
    pecu_pkg::pecu_branch_t br;
    logic [2:0]             br_exec_count = 3'h0;
    logic                   retire = 1'b0;
    pecu_pkg::pecu_miss_t   miss;
    pecu_pkg::pecu_fill_t   fill;
    logic                   branch_captured;
    logic                   cache_captured;
    logic [2:0]             br_exec_event;
    logic                   retire_event;
    logic                   miss_pending;
    int                     miscompares = 0;
    int                     tests_run = 0;
    int                     cycles = 0;
    logic [63:0]            va = 64'h0123_4567_89ab_c000;
    logic [31:0]            ia = 32'h1234_5674;
    localparam logic [39:0] PA = 40'h5a_9876_5432;
    // branch cases: control, class, taken/predicted/watch, captured
    logic [38:0] bt [10] = '{{32'h0000_42f8, 3'd0, 3'b010, 1'b1},
        {32'h0000_41f8, 3'd0, 3'b010, 1'b0}, {32'h0000_43d8, 3'd0, 3'b010, 1'b0},
        {32'h0000_43e8, 3'd0, 3'b010, 1'b1}, {32'h0000_43b8, 3'd0, 3'b110, 1'b0},
        {32'h0000_1378, 3'd2, 3'b100, 1'b1}, {32'h0000_13b8, 3'd2, 3'b100, 1'b0},
        {32'h0000_23d8, 3'd1, 3'b100, 1'b1}, {32'h0000_c3f8, 3'd0, 3'b110, 1'b0},
        {32'h0000_c3f8, 3'd0, 3'b111, 1'b1}};
    // miss cases: control, kind 0 fetch 1 load 2 store, dwatch/iwatch, captured
    logic [36:0] mt [12] = '{{32'h0002_0008, 2'd1, 3'b001},
        {32'h0004_0008, 2'd1, 3'b000}, {32'h0001_0008, 2'd2, 3'b001},
        {32'h0004_0008, 2'd0, 3'b001}, {32'h000a_0008, 2'd1, 3'b000},
        {32'h000a_0008, 2'd1, 3'b101}, {32'h0009_0008, 2'd2, 3'b001},
        {32'h0014_0008, 2'd0, 3'b000}, {32'h0014_0008, 2'd0, 3'b011},
        {32'h0012_0008, 2'd1, 3'b000}, {32'h0011_0008, 2'd2, 3'b001},
        {32'h0007_0004, 2'd1, 3'b000}};

    pecu_top pecu_top_i (.sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .mode, .br, .br_exec_count, .retire, .miss, .fill,
        .branch_captured, .cache_captured, .br_exec_event, .retire_event,
        .miss_pending);
    pecu_core_model pecu_core_model_i (.sys_clk, .br, .miss, .fill);

    always #25 sys_clk = ~sys_clk;

    // ****************************************
    // access and compare tasks
    // ****************************************
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: reg %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: flag %b want %b", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic br_try(input logic [38:0] t);
        va = va + 64'h10;
        wr(pecu_pkg::ADDR_CTRL, t[38:7]);
        pecu_core_model_i.send_br({1'b1, pecu_pkg::pecu_br_class_t'(t[6:4]), t[3:1], va});
        chk_bit(branch_captured, t[0]);
        if (t[0]) ia = {va[31:2], 1'b0, t[3]};
        rd_chk(pecu_pkg::ADDR_IADDR_LO, ia);
    endtask
    task automatic ms_try(input logic [36:0] t);
        logic [2:0] k;
        k = {t[4:3] == 2'd0, t[4:3] == 2'd1, t[4:3] == 2'd2};
        va = va + 64'h10;
        wr(pecu_pkg::ADDR_CTRL, t[36:5]);
        pecu_core_model_i.send_miss({k, t[2:1], va, PA});
        chk_bit(cache_captured, t[0]);
        if (t[0] && k[1]) ia = {va[31:2], 2'b10};
        rd_chk(pecu_pkg::ADDR_IADDR_LO, ia);
        if (t[0]) rd_chk(pecu_pkg::ADDR_MADDR_HI, {1'b1, k, 20'h0_0000, PA[39:32]});
    endtask
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            close_out();
        end
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd_chk(pecu_pkg::ADDR_MADDR_HI, 32'h0000_0000);
        rd_chk(3'h5, 32'h0000_0000);
        wr(pecu_pkg::ADDR_CTRL, 32'hffff_ffff);
        rd_chk(pecu_pkg::ADDR_CTRL, 32'h001f_ffff);
        wr(pecu_pkg::ADDR_IADDR_LO, 32'h1234_5677);
        rd_chk(pecu_pkg::ADDR_IADDR_LO, 32'h1234_5674);
        wr(pecu_pkg::ADDR_MADDR_LO, 32'hffff_ffff);
        rd_chk(pecu_pkg::ADDR_MADDR_LO, 32'h0000_0000);
        $display("register test done");
        br_try({32'h0000_43ff, 3'd0, 3'b110, 1'b0});
        for (int m = 0; m < 4; m++) begin
            @(posedge sys_clk);
            mode <= pecu_pkg::pecu_mode_t'(4'h1 << m);
            br_try({32'h0000_43f0 | (32'h1 << m), 3'd0, 3'b110, 1'b1});
            br_try({32'h0000_43f0 | (32'h1 << ((m + 1) % 4)), 3'd0, 3'b110, 1'b0});
        end
        @(posedge sys_clk);
        mode <= 4'h8;
        for (int c = 0; c < 5; c++) begin
            br_try({32'h0000_03f8 | (32'h1 << (14 - c)), c[2:0], 3'b110, 1'b1});
            br_try({32'h0000_03f8 | (32'h1 << (14 - (c + 1) % 5)), c[2:0], 3'b110, 1'b0});
        end
        foreach (bt[i]) br_try(bt[i]);
        rd_chk(pecu_pkg::ADDR_IADDR_HI, va[63:32]);
        $display("branch test done");
        foreach (mt[i]) ms_try(mt[i]);
        rd_chk(pecu_pkg::ADDR_MADDR_LO, {PA[31:5], 5'h00});
        for (int s = 0; s < 4; s++) begin
            ms_try({32'h0002_0008, 2'd1, 3'b001});
            chk_bit(miss_pending, 1'b1);
            pecu_core_model_i.send_fill({1'b1, pecu_pkg::pecu_src_t'(s), s[0]});
            rd_chk(pecu_pkg::ADDR_MADDR_HI, {4'b0010, 4'b1000 >> s, s[0], 15'h0000, PA[39:32]});
            chk_bit(miss_pending, 1'b0);
        end
        $display("miss test done");
        @(posedge sys_clk);
        br_exec_count <= 3'h7;
        retire <= 1'b1;
        @(posedge sys_clk);
        br_exec_count <= 3'h3;
        retire <= 1'b0;
        #1 chk({29'h0, br_exec_event}, 32'h0000_0004);
        chk_bit(retire_event, 1'b1);
        @(posedge sys_clk);
        #1 chk({29'h0, br_exec_event}, 32'h0000_0003);
        $display("count test done");
        close_out();
    end
endmodule
`default_nettype wire

// >>> src/pecu_pkg.sv
// pecu_pkg: constants, field positions and carrier types of the event capture unit
// assumes: shared by the capture top and its qualifier module
package pecu_pkg;

    // ****************************************
    // register indices (word addresses)
    // ****************************************
    localparam logic [2:0] ADDR_CTRL      = 3'h0;
    localparam logic [2:0] ADDR_IADDR_LO  = 3'h1;
    localparam logic [2:0] ADDR_IADDR_HI  = 3'h2;
    localparam logic [2:0] ADDR_MADDR_LO  = 3'h3;
    localparam logic [2:0] ADDR_MADDR_HI  = 3'h4;
    localparam logic [2:0] ADDR_EVCOUNT   = 3'h5;

    // ****************************************
    // control field positions
    // ****************************************
    localparam int CTL_EXL   = 0;
    localparam int CTL_KERN  = 1;
    localparam int CTL_SUP   = 2;
    localparam int CTL_USER  = 3;
    localparam int CTL_GOOD  = 4;
    localparam int CTL_WRONG = 5;
    localparam int CTL_PT    = 6;
    localparam int CTL_PN    = 7;
    localparam int CTL_OT    = 8;
    localparam int CTL_ON    = 9;
    localparam int CTL_CALL  = 10;
    localparam int CTL_RET   = 11;
    localparam int CTL_IND   = 12;
    localparam int CTL_JMP   = 13;
    localparam int CTL_COND  = 14;
    localparam int CTL_BWI   = 15;
    localparam int CTL_ST    = 16;
    localparam int CTL_LD    = 17;
    localparam int CTL_IF    = 18;
    localparam int CTL_CWD   = 19;
    localparam int CTL_CWI   = 20;
    localparam logic [31:0] CTL_WMASK = 32'h001f_ffff;
    localparam logic [31:0] CTL_RESET = 32'h0000_0000;

    // ****************************************
    // miss register field positions
    // ****************************************
    localparam int MA_PEND  = 63;
    localparam int MA_IF    = 62;
    localparam int MA_LD    = 61;
    localparam int MA_ST    = 60;
    localparam int MA_PROC  = 59;
    localparam int MA_L2    = 58;
    localparam int MA_MEM   = 57;
    localparam int MA_OTHER = 56;
    localparam int MA_DIRTY = 55;
    localparam int MA_PA_HI = 39;
    localparam int MA_PA_LO = 5;

    // ****************************************
    // capture kind codes and limits
    // ****************************************
    localparam logic [1:0] KIND_NT   = 2'h0;
    localparam logic [1:0] KIND_TK   = 2'h1;
    localparam logic [1:0] KIND_LOAD = 2'h2;
    localparam logic [2:0] BR_MAX    = 3'h4;
    localparam logic [2:0] RET_MAX   = 3'h1;

    typedef enum logic [2:0] {
        PECU_BR_COND,
        PECU_BR_JUMP,
        PECU_BR_IND,
        PECU_BR_RET,
        PECU_BR_CALL
    } pecu_br_class_t;

    typedef enum logic [1:0] {
        PECU_SRC_PROC,
        PECU_SRC_L2,
        PECU_SRC_MEM,
        PECU_SRC_OTHER
    } pecu_src_t;

    typedef struct packed {
        logic           user;
        logic           sup;
        logic           kern;
        logic           exception_level_enable;
    } pecu_mode_t;

    typedef struct packed {
        logic           valid;
        pecu_br_class_t cls;
        logic           taken;
        logic           pred_taken;
        logic           iwatch;
        logic [63:0]    vaddr;
    } pecu_branch_t;

    typedef struct packed {
        logic           ifetch;
        logic           load;
        logic           store;
        logic           dwatch;
        logic           iwatch;
        logic [63:0]    vaddr;
        logic [39:0]    paddr;
    } pecu_miss_t;

    typedef struct packed {
        logic           valid;
        pecu_src_t      src;
        logic           dirty;
    } pecu_fill_t;

endpackage

// >>> src/pecu_qualify.sv
// pecu_qualify: combinational filter of branch and cache miss events
// assumes: inputs on the core clock; outputs sampled by the capture top
`timescale 1ns/1ns
`default_nettype none
module pecu_qualify (
    // control and context
    input  wire logic [31:0]          ctrl,
    input  wire pecu_pkg::pecu_mode_t mode,
    // events
    input  wire pecu_pkg::pecu_branch_t br,
    input  wire pecu_pkg::pecu_miss_t   miss,
    // verdicts
    output logic                      br_ok,
    output logic                      if_ok,
    output logic                      ld_ok,
    output logic                      st_ok
);

    // pair filter: both set passes all, one set passes its class, none passes none
    function automatic logic pair_ok(input logic set_one, input logic set_zero,
                                     input logic sel);
        pair_ok = sel ? set_one : set_zero;
    endfunction

    logic mode_ok;
    logic eff_pt;
    logic eff_ok;
    logic cls_ok;

    always_comb begin
        // one privilege gate shared by every source
        mode_ok = (mode.user & ctrl[pecu_pkg::CTL_USER]) | (mode.sup & ctrl[pecu_pkg::CTL_SUP])
                | (mode.kern & ctrl[pecu_pkg::CTL_KERN])
                | (mode.exception_level_enable & ctrl[pecu_pkg::CTL_EXL]);
        // all non-conditional classes predict taken; jumps always predict right
        eff_pt = (br.cls == pecu_pkg::PECU_BR_COND) ? br.pred_taken : 1'b1;
        eff_ok = (br.cls == pecu_pkg::PECU_BR_JUMP) ? 1'b1 : (eff_pt == br.taken);
        unique case (br.cls)
            pecu_pkg::PECU_BR_COND: cls_ok = ctrl[pecu_pkg::CTL_COND];
            pecu_pkg::PECU_BR_JUMP: cls_ok = ctrl[pecu_pkg::CTL_JMP];
            pecu_pkg::PECU_BR_IND:  cls_ok = ctrl[pecu_pkg::CTL_IND];
            pecu_pkg::PECU_BR_RET:  cls_ok = ctrl[pecu_pkg::CTL_RET];
            pecu_pkg::PECU_BR_CALL: cls_ok = ctrl[pecu_pkg::CTL_CALL];
            default:                cls_ok = 1'b0;
        endcase
        br_ok = br.valid & mode_ok & cls_ok
              & pair_ok(ctrl[pecu_pkg::CTL_GOOD], ctrl[pecu_pkg::CTL_WRONG], eff_ok)
              & pair_ok(ctrl[pecu_pkg::CTL_PT], ctrl[pecu_pkg::CTL_PN], eff_pt)
              & pair_ok(ctrl[pecu_pkg::CTL_OT], ctrl[pecu_pkg::CTL_ON], br.taken)
              & (~ctrl[pecu_pkg::CTL_BWI] | br.iwatch);
        // separate path per access type, each with its own filter subset
        if_ok = miss.ifetch & mode_ok & ctrl[pecu_pkg::CTL_IF]
              & (~ctrl[pecu_pkg::CTL_CWI] | miss.iwatch);
        ld_ok = miss.load & mode_ok & ctrl[pecu_pkg::CTL_LD]
              & (~ctrl[pecu_pkg::CTL_CWD] | miss.dwatch)
              & (~ctrl[pecu_pkg::CTL_CWI] | miss.iwatch);
        st_ok = miss.store & mode_ok & ctrl[pecu_pkg::CTL_ST];
    end

endmodule
`default_nettype wire

// >>> src/pecu_top.sv
// pecu_top: performance event capture unit with filter control and capture registers
// assumes: event inputs come from core-clock logic; fill return is one-cycle pulse
//
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module pecu_top (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   reset_n,
    // register port
    input  wire logic [2:0]             reg_addr,
    input  wire logic [31:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic [31:0]                 reg_rdata,
    // core context and events
    input  wire pecu_pkg::pecu_mode_t   mode,
    input  wire pecu_pkg::pecu_branch_t br,
    input  wire logic [2:0]             br_exec_count,
    input  wire logic                   retire,
    input  wire pecu_pkg::pecu_miss_t   miss,
    input  wire pecu_pkg::pecu_fill_t   fill,
    // event outputs
    output logic                        branch_captured,
    output logic                        cache_captured,
    output logic [2:0]                  br_exec_event,
    output logic                        retire_event,
    output logic                        miss_pending
);

    // ****************************************
    // reset release
    // ****************************************
    logic rst_meta_reg;
    logic rst_n_reg;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // ****************************************
    // qualification
    // ****************************************
    logic [31:0] ctrl_reg;
    logic        br_ok;
    logic        if_ok;
    logic        ld_ok;
    logic        st_ok;
    logic        miss_ok;

    pecu_qualify u_qual (
        .ctrl  (ctrl_reg),
        .mode  (mode),
        .br    (br),
        .miss  (miss),
        .br_ok (br_ok),
        .if_ok (if_ok),
        .ld_ok (ld_ok),
        .st_ok (st_ok)
    );

    assign miss_ok = if_ok | ld_ok | st_ok;

    // ****************************************
    // filter control register
    // ****************************************
    logic wr_ctrl;
    logic wr_ia_lo;
    logic wr_ia_hi;

    assign wr_ctrl  = reg_wr & (reg_addr == pecu_pkg::ADDR_CTRL);
    assign wr_ia_lo = reg_wr & (reg_addr == pecu_pkg::ADDR_IADDR_LO);
    assign wr_ia_hi = reg_wr & (reg_addr == pecu_pkg::ADDR_IADDR_HI);

    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            ctrl_reg <= pecu_pkg::CTL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= reg_wdata & pecu_pkg::CTL_WMASK;
        end
    end

    // ****************************************
    // instruction address capture
    // ****************************************
    logic [63:2] iaddr_reg;
    logic [1:0]  ikind_reg;

    // hardware capture wins over a software write in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            iaddr_reg <= 62'h0;
            ikind_reg <= pecu_pkg::KIND_NT;
        end else if (br_ok) begin
            iaddr_reg <= br.vaddr[63:2];
            ikind_reg <= br.taken ? pecu_pkg::KIND_TK : pecu_pkg::KIND_NT;
        end else if (ld_ok) begin
            iaddr_reg <= miss.vaddr[63:2];
            ikind_reg <= pecu_pkg::KIND_LOAD;
        end else if (wr_ia_lo) begin
            iaddr_reg[31:2] <= reg_wdata[31:2];
        end else if (wr_ia_hi) begin
            iaddr_reg[63:32] <= reg_wdata;
        end
    end

    // ****************************************
    // miss line capture and return tracking
    // ****************************************
    logic [39:5] line_reg;
    logic [2:0]  mtype_reg;
    logic        pend_reg;
    logic [3:0]  src_reg;
    logic        dirty_reg;

    // a new capture starts a fresh pending miss; a return in the same cycle as a capture is dropped
    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            line_reg  <= 35'h0;
            mtype_reg <= 3'h0;
            pend_reg  <= 1'b0;
            src_reg   <= 4'h0;
            dirty_reg <= 1'b0;
        end else if (miss_ok) begin
            line_reg  <= miss.paddr[pecu_pkg::MA_PA_HI:pecu_pkg::MA_PA_LO];
            mtype_reg <= {if_ok, ld_ok & ~if_ok, st_ok & ~if_ok & ~ld_ok};
            pend_reg  <= 1'b1;
            src_reg   <= 4'h0;
            dirty_reg <= 1'b0;
        end else if (fill.valid && pend_reg) begin
            pend_reg  <= 1'b0;
            src_reg   <= 4'h8 >> fill.src;
            dirty_reg <= fill.dirty;
        end
    end

    // ****************************************
    // event outputs
    // ****************************************
    localparam logic RET_ONE = pecu_pkg::RET_MAX[0];

    // branches count after validation, retirement after graduation
    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            branch_captured <= 1'b0;
            cache_captured  <= 1'b0;
            br_exec_event   <= 3'h0;
            retire_event    <= 1'b0;
        end else begin
            branch_captured <= br_ok;
            cache_captured  <= miss_ok;
            br_exec_event   <= (br_exec_count > pecu_pkg::BR_MAX) ? pecu_pkg::BR_MAX
                                                                  : br_exec_count;
            retire_event    <= retire & RET_ONE;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            miss_pending <= 1'b0;
        end else begin
            miss_pending <= miss_ok | (pend_reg & ~fill.valid);
        end
    end

    // ****************************************
    // read port
    // ****************************************
    logic [63:0] maddr_view;

    assign maddr_view = {pend_reg, mtype_reg, src_reg, dirty_reg, 15'h0,
                         line_reg, 5'h0};

    // unmapped indices read zero; one-cycle read latency
    always_ff @(posedge sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                pecu_pkg::ADDR_CTRL:     reg_rdata <= ctrl_reg;
                pecu_pkg::ADDR_IADDR_LO: reg_rdata <= {iaddr_reg[31:2], ikind_reg};
                pecu_pkg::ADDR_IADDR_HI: reg_rdata <= iaddr_reg[63:32];
                pecu_pkg::ADDR_MADDR_LO: reg_rdata <= maddr_view[31:0];
                pecu_pkg::ADDR_MADDR_HI: reg_rdata <= maddr_view[63:32];
                default:                 reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire
